// [host_model.sv]
// host microcontroller model driving the two-wire serial port
// assumes the device answers on dev_out/dev_oe in the serial clock domain
`timescale 1ns/1ps
module host_model (
   // serial clock and data line seen by the device
   output logic sck,
   output logic sdio,
   // device side of the data pin
   input wire logic dev_out,
   input wire logic dev_oe
);
   logic drv;
   logic bit_q;
   logic last;
   // sck rests high between frames; an undriven line shows the inverse of its last level
   assign sdio = dev_oe ? dev_out : (drv ? bit_q : ~last);
   always @(posedge sck) last <= sdio;
   initial begin
      sck = 1'b1;
      drv = 1'b1;
      bit_q = 1'b0;
      last = 1'b0;
   end
   // data changes after the falling edge, the device samples on the rising edge
   task automatic put_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         drv = 1'b1;
         bit_q = b[i];
         #3;
         sck = 1'b1;
         #3;
      end
   endtask : put_byte
   // spacing between frames
   task automatic gap();
      #100000;
   endtask : gap
   // address byte with direction one, then data, msb first
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      put_byte({1'b1, a});
      put_byte(d);
   endtask : wr
   // line released after the address, then time for the device to prepare data
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      put_byte({1'b0, a});
      drv = 1'b0;
      #100000;
      d = 8'h00;
      for (int i = 0; i < 8; i++) begin
         sck = 1'b0;
         #3;
         d = {d[6:0], sdio};
         sck = 1'b1;
         #3;
      end
   endtask : rd
endmodule : host_model

// [sensor_defs.svh]
// constants of the sensor power-down and serial-port control block
// assumes a 20 MHz core clock; included by bare name
`ifndef SENSOR_DEFS_SVH
`define SENSOR_DEFS_SVH

// register map and fields
`define CFG_ADDR 7'h00
`define CFG_RESET 8'h00
`define SLEEP_REQUEST_BIT 6

// timing, each time in its own unit
`define CLK_KHZ 20000
`define SLEEP_ENTRY_NS 1330
`define SLEEP_ENTRY_CLKS 32
`define TRANSACTION_TIMEOUT_MS 90
`define REPORT_BASE_US 610
`define FRAME_RATE_HZ 1500
`define WAKE_FRAMES 75
`define SUPPLY_FRAMES 50
`define WAKE_REPORT_MS 50
`define SUPPLY_REPORT_MS 40

// serial framing
`define XFER_BITS 16

`endif

// [sensor_pkg.sv]
// types shared by the power-down controller and its serial link
// assumes sensor_defs.svh for all figures
package sensor_pkg;

   typedef enum logic [1:0] {
      ST_AWAKE,
      ST_ENTERING,
      ST_ASLEEP
   } sleep_state_t;

   typedef struct packed {
      logic [4:0] bit_cnt;
      logic busy;
      logic dir;
      logic [6:0] addr;
      logic [7:0] shift;
      logic [7:0] wdata;
      logic wr_tog;
      logic sdo;
      logic oe;
      logic [7:0] cfg_s1;
      logic [7:0] cfg_s2;
   } link_state_t;

   typedef struct packed {
      sleep_state_t state;
      logic [7:0] cfg;
      logic [5:0] entry_cnt;
      logic analog_on;
      logic [31:0] tmo_cnt;
      logic link_rst_n;
      logic [31:0] rep_cnt;
      logic report_valid;
      logic busy_s1;
      logic busy_s2;
      logic tog_s1;
      logic tog_s2;
      logic tog_s3;
      logic shutter;
      logic shutter_oe;
   } top_state_t;

endpackage : sensor_pkg

// [sensor_power_down_control.sv]
// power-down control and serial-port watchdog of the motion sensor
// assumes CLK at 20 MHz; SCK and SDIO come from the host and are asynchronous to CLK
`timescale 1ns/1ps
`include "sensor_defs.svh"
module sensor_power_down_control
   import sensor_pkg::*;
#(
   // transaction watchdog, typical figure
   parameter int TIMEOUT_CYC = `TRANSACTION_TIMEOUT_MS * `CLK_KHZ,
   // wake to valid reports, capped at the documented maximum
   parameter int WAKE_CYC =
      ((`REPORT_BASE_US * `CLK_KHZ / 1000)
       + `WAKE_FRAMES * (`CLK_KHZ * 1000 / `FRAME_RATE_HZ))
      < (`WAKE_REPORT_MS * `CLK_KHZ)
      ? ((`REPORT_BASE_US * `CLK_KHZ / 1000)
         + `WAKE_FRAMES * (`CLK_KHZ * 1000 / `FRAME_RATE_HZ))
      : (`WAKE_REPORT_MS * `CLK_KHZ),
   // supply power-up to valid reports
   parameter int SUPPLY_CYC =
      ((`REPORT_BASE_US * `CLK_KHZ / 1000)
       + `SUPPLY_FRAMES * (`CLK_KHZ * 1000 / `FRAME_RATE_HZ))
      < (`SUPPLY_REPORT_MS * `CLK_KHZ)
      ? ((`REPORT_BASE_US * `CLK_KHZ / 1000)
         + `SUPPLY_FRAMES * (`CLK_KHZ * 1000 / `FRAME_RATE_HZ))
      : (`SUPPLY_REPORT_MS * `CLK_KHZ)
)
(
   // core clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // serial port pins
   input wire logic SCK,
   input wire logic SDIO_IN,
   output logic SDIO_OUT,
   output logic SDIO_OE,
   // shutter drive
   input wire logic FRAME_SHUTTER,
   output logic SHUTTER_DRIVE_OUT,
   output logic SHUTTER_OE,
   // power state
   output logic ANALOG_ON,
   output logic REPORT_VALID
);

   // the entry wait is the longer of the printed time and the printed cycle count
   localparam int ENTRY_NS_CYC = (`SLEEP_ENTRY_NS * `CLK_KHZ + 999999) / 1000000;
   localparam int ENTRY_CYC =
      (ENTRY_NS_CYC > `SLEEP_ENTRY_CLKS) ? ENTRY_NS_CYC : `SLEEP_ENTRY_CLKS;

   localparam top_state_t TOP_RESET = '{
      state: ST_AWAKE,
      cfg: `CFG_RESET,
      entry_cnt: 6'h00,
      analog_on: 1'b1,
      tmo_cnt: 32'h0000_0000,
      link_rst_n: 1'b0,
      rep_cnt: 32'(SUPPLY_CYC),
      report_valid: 1'b0,
      busy_s1: 1'b0,
      busy_s2: 1'b0,
      tog_s1: 1'b0,
      tog_s2: 1'b0,
      tog_s3: 1'b0,
      shutter: 1'b0,
      shutter_oe: 1'b1
   };

   top_state_t q;
   top_state_t d;

   // link side outputs
   logic link_busy;
   logic link_wr_tog;
   logic [6:0] link_addr;
   logic [7:0] link_wdata;
   logic link_sdo;
   logic link_oe;

   // core-side view of the crossing
   logic wr_evt;
   logic asleep_req;

   assign wr_evt = q.tog_s2 ^ q.tog_s3;
   assign asleep_req = q.cfg[`SLEEP_REQUEST_BIT];

   // serial engine in the SCK domain; its reset is a core flop so the
   // watchdog can abort a stuck frame even with SCK standing still
   serial_link serial_link_inst (
      .sck(SCK),
      .rst_n(q.link_rst_n),
      .sdio_in(SDIO_IN),
      .sdo(link_sdo),
      .oe(link_oe),
      .cfg(q.cfg),
      .busy(link_busy),
      .wr_tog(link_wr_tog),
      .addr(link_addr),
      .wdata(link_wdata)
   );

   always_comb begin
      d = q;

      // level and toggle crossings from the link
      d.busy_s1 = link_busy;
      d.busy_s2 = q.busy_s1;
      d.tog_s1 = link_wr_tog;
      d.tog_s2 = q.tog_s1;
      d.tog_s3 = q.tog_s2;
      d.link_rst_n = 1'b1;

      // address and data stay still until the next frame, well after the toggle lands
      if (wr_evt && link_addr == `CFG_ADDR) begin
         if (asleep_req) begin
            d.cfg[`SLEEP_REQUEST_BIT] = link_wdata[`SLEEP_REQUEST_BIT];
         end else begin
            d.cfg = link_wdata;
         end
      end

      // watchdog runs from the first synced edge of a frame
      if (q.busy_s2 && !asleep_req) begin
         if (q.tmo_cnt >= 32'(TIMEOUT_CYC - 1)) begin
            d.tmo_cnt = 32'h0000_0000;
            d.link_rst_n = 1'b0;
         end else begin
            d.tmo_cnt = q.tmo_cnt + 32'h0000_0001;
         end
      end else begin
         d.tmo_cnt = 32'h0000_0000;
      end

      // report-valid countdown only runs while awake
      if (q.state == ST_AWAKE) begin
         if (q.rep_cnt != 32'h0000_0000) begin
            d.rep_cnt = q.rep_cnt - 32'h0000_0001;
         end else begin
            d.report_valid = 1'b1;
         end
      end

      case (q.state)
         ST_AWAKE: begin
            if (asleep_req) begin
               d.state = ST_ENTERING;
               d.entry_cnt = 6'h00;
               d.report_valid = 1'b0;
            end
         end
         ST_ENTERING: begin
            if (!asleep_req) begin
               // cancelled before analog went down, nothing to recover
               d.state = ST_AWAKE;
            end else if (q.entry_cnt == 6'(ENTRY_CYC - 1)) begin
               d.state = ST_ASLEEP;
               d.analog_on = 1'b0;
            end else begin
               d.entry_cnt = q.entry_cnt + 6'h01;
            end
         end
         ST_ASLEEP: begin
            if (!asleep_req) begin
               d.state = ST_AWAKE;
               d.analog_on = 1'b1;
               d.rep_cnt = 32'(WAKE_CYC);
               d.report_valid = 1'b0;
            end
         end
         default: begin
            d.state = ST_AWAKE;
         end
      endcase

      // shutter released as soon as sleep is requested
      d.shutter = FRAME_SHUTTER && q.analog_on && !asleep_req;
      d.shutter_oe = !asleep_req;
   end

   // cfg has no path back to reset except RST_N, so settings survive sleep
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         q <= TOP_RESET;
      end else begin
         q <= d;
      end
   end

   assign SDIO_OUT = link_sdo;
   assign SDIO_OE = link_oe;
   assign SHUTTER_DRIVE_OUT = q.shutter;
   assign SHUTTER_OE = q.shutter_oe;
   assign ANALOG_ON = q.analog_on;
   assign REPORT_VALID = q.report_valid;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   sequence s_cfg_write;
      wr_evt && link_addr == `CFG_ADDR;
   endsequence

   sequence s_wake;
      q.state == ST_ASLEEP && !asleep_req;
   endsequence

   a_sleep_entry: assert property (
      (q.state == ST_AWAKE && asleep_req) |=> q.state == ST_ENTERING && q.entry_cnt == 6'h00)
      else $error("sleep request did not start the entry wait");

   a_entry_wait: assert property (
      (q.state == ST_ENTERING) |-> q.analog_on)
      else $error("analog turned off before entry wait ended");

   a_entry_len: assert property (
      $rose(q.state == ST_ASLEEP) |-> !q.analog_on && $past(q.entry_cnt) == 6'h1f)
      else $error("power-down entered after wrong wait");

   a_sleep_mask: assert property (
      (s_cfg_write and asleep_req)
      |=> q.cfg[7] == $past(q.cfg[7]) && q.cfg[5:0] == $past(q.cfg[5:0])
         && q.cfg[6] == $past(link_wdata[6]))
      else $error("write in power-down touched bits other than the sleep bit");

   a_awake_write: assert property (
      (s_cfg_write and !asleep_req) |=> q.cfg == $past(link_wdata))
      else $error("configuration write while awake not stored");

   a_bad_addr: assert property (
      !(wr_evt && link_addr == `CFG_ADDR) |=> $stable(q.cfg))
      else $error("configuration changed without a write");

   a_no_timeout_asleep: assert property (
      asleep_req |=> q.link_rst_n)
      else $error("watchdog fired during power-down");

   a_timeout: assert property (
      (q.busy_s2 && !asleep_req && q.tmo_cnt == 32'(TIMEOUT_CYC - 1))
      |=> !q.link_rst_n ##1 q.link_rst_n)
      else $error("watchdog did not reset the serial port");

   a_shutter_hiz: assert property (
      asleep_req |=> !SHUTTER_OE && !SHUTTER_DRIVE_OUT)
      else $error("shutter output still driven in power-down");

   a_wake_report: assert property (
      s_wake |=> !REPORT_VALID && q.rep_cnt == 32'(WAKE_CYC) && q.analog_on)
      else $error("wake did not restart the report delay");

   a_report_ready: assert property (
      (q.state == ST_AWAKE && !asleep_req && q.rep_cnt == 32'h0000_0001)
      |=> ##1 REPORT_VALID)
      else $error("reports not flagged valid when delay ran out");

   // entry wait steps one count per core cycle while the request stands
   sequence s_entry_step;
      q.state == ST_ENTERING && asleep_req && q.entry_cnt != 6'(ENTRY_CYC - 1);
   endsequence

   a_entry_step: assert property (
      s_entry_step
      |=> q.state == ST_ENTERING && q.entry_cnt == $past(q.entry_cnt) + 6'h01)
      else $error("entry wait did not advance by one");

   // analog and shutter follow the power state
   a_entry_cancel: assert property (
      (q.state == ST_ENTERING && !asleep_req)
      |=> q.state == ST_AWAKE && ANALOG_ON)
      else $error("cancelled sleep did not return awake");

   a_asleep_hold: assert property (
      (q.state == ST_ASLEEP && asleep_req)
      |=> q.state == ST_ASLEEP && !ANALOG_ON)
      else $error("analog circuitry woke without a clearing write");

   a_analog_awake: assert property (
      (q.state == ST_AWAKE)
      |-> ANALOG_ON)
      else $error("analog circuitry off while awake");

   a_shutter_gate: assert property (
      !ANALOG_ON
      |=> !SHUTTER_DRIVE_OUT)
      else $error("shutter pulsed with analog circuitry off");

   a_shutter_back: assert property (
      !asleep_req
      |=> SHUTTER_OE)
      else $error("shutter output not driven while awake");

   // watchdog counts only while a frame is open and the device is awake
   a_tmo_idle: assert property (
      !q.busy_s2
      |=> q.tmo_cnt == 32'h0000_0000)
      else $error("watchdog counted with no frame open");

   a_tmo_asleep: assert property (
      asleep_req
      |=> q.tmo_cnt == 32'h0000_0000)
      else $error("watchdog counted during power-down");

   a_tmo_count: assert property (
      (q.busy_s2 && !asleep_req && q.tmo_cnt < 32'(TIMEOUT_CYC - 1))
      |=> q.tmo_cnt == $past(q.tmo_cnt) + 32'h0000_0001 && q.link_rst_n)
      else $error("watchdog skipped a count or fired early");

   // report flag only stands while awake and holds until the next sleep request
   a_report_hidden: assert property (
      (q.state != ST_AWAKE)
      |-> !REPORT_VALID)
      else $error("reports flagged valid outside the awake state");

   a_report_hold: assert property (
      (REPORT_VALID && q.state == ST_AWAKE && !asleep_req)
      |=> REPORT_VALID)
      else $error("valid reports dropped without a sleep request");

   a_report_count: assert property (
      (q.state == ST_AWAKE && !asleep_req && q.rep_cnt != 32'h0000_0000)
      |=> q.rep_cnt == $past(q.rep_cnt) - 32'h0000_0001 && !REPORT_VALID)
      else $error("report delay did not count down");

endmodule : sensor_power_down_control

// [sensor_power_down_control_test.sv]
// self-checking bench of the power-down controller with a host model
// assumes shortened watchdog and report counts via parameters
`timescale 1ns/1ps
module sensor_power_down_control_test;
   // watchdog must outlast two back-to-back reads, each holding a 100 us pause
   localparam int TMO = 5000;
   localparam int WAKE = 100;
   localparam int SUP = 50;
   logic clk;
   logic rst_n;
   logic sck;
   logic sdio_in;
   logic sdio_out;
   logic sdio_oe;
   logic frame_shutter;
   logic shutter_drive_out;
   logic shutter_oe;
   logic analog_on;
   logic report_valid;
   logic oe_seen;
   logic [7:0] rdv;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;

   sensor_power_down_control #(.TIMEOUT_CYC(TMO), .WAKE_CYC(WAKE), .SUPPLY_CYC(SUP))
   sensor_power_down_control_inst (
      .CLK(clk), .RST_N(rst_n), .SCK(sck), .SDIO_IN(sdio_in), .SDIO_OUT(sdio_out),
      .SDIO_OE(sdio_oe), .FRAME_SHUTTER(frame_shutter),
      .SHUTTER_DRIVE_OUT(shutter_drive_out), .SHUTTER_OE(shutter_oe),
      .ANALOG_ON(analog_on), .REPORT_VALID(report_valid)
   );
   host_model host_model_inst (
      .sck(sck), .sdio(sdio_in), .dev_out(sdio_out), .dev_oe(sdio_oe)
   );

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge sdio_oe) oe_seen = 1'b1;

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   // guards against a hung serial port or a stuck wait
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         n_errors++;
         wrap_up();
      end
   end

   task automatic t_reset();
      repeat (SUP - 1) @(negedge clk);
      chk("report_valid", 8'h00, {7'h00, report_valid});
      frame_shutter = 1'b1;
      repeat (3) @(negedge clk);
      chk("report_valid", 8'h01, {7'h00, report_valid});
      chk("shutter_drive", 8'h01, {7'h00, shutter_drive_out});
      host_model_inst.rd(7'h00, rdv);
      chk("cfg reset", 8'h00, rdv);
   endtask : t_reset

   task automatic t_config();
      host_model_inst.wr(7'h00, 8'h05);
      host_model_inst.gap();
      host_model_inst.wr(7'h77, 8'hff);
      host_model_inst.gap();
      oe_seen = 1'b0;
      host_model_inst.rd(7'h00, rdv);
      chk("cfg", 8'h05, rdv);
      chk("sdio_oe awake", 8'h01, {7'h00, oe_seen});
      host_model_inst.rd(7'h77, rdv);
      chk("unmapped", 8'h00, rdv);
   endtask : t_config

   // a lone address byte must be dropped by the watchdog, not merged with the next frame
   task automatic t_watchdog();
      host_model_inst.put_byte(8'h80);
      repeat (2 * TMO) @(negedge clk);
      host_model_inst.wr(7'h00, 8'h09);
      host_model_inst.gap();
      host_model_inst.rd(7'h00, rdv);
      chk("cfg after timeout", 8'h09, rdv);
   endtask : t_watchdog

   task automatic t_sleep();
      host_model_inst.wr(7'h00, 8'h49);
      repeat (8) @(negedge clk);
      chk("shutter_oe", 8'h00, {7'h00, shutter_oe});
      chk("analog early", 8'h01, {7'h00, analog_on});
      repeat (40) @(negedge clk);
      chk("analog asleep", 8'h00, {7'h00, analog_on});
      chk("shutter_drive asleep", 8'h00, {7'h00, shutter_drive_out});
      host_model_inst.gap();
      oe_seen = 1'b0;
      host_model_inst.rd(7'h00, rdv);
      chk("sdio_oe asleep", 8'h00, {7'h00, oe_seen});
      host_model_inst.wr(7'h00, 8'h02);
      repeat (10) @(negedge clk);
      chk("analog awake", 8'h01, {7'h00, analog_on});
      chk("report early", 8'h00, {7'h00, report_valid});
      repeat (WAKE - 10) @(negedge clk);
      chk("report early", 8'h00, {7'h00, report_valid});
      repeat (12) @(negedge clk);
      chk("report awake", 8'h01, {7'h00, report_valid});
      chk("shutter_oe awake", 8'h01, {7'h00, shutter_oe});
      host_model_inst.gap();
      host_model_inst.rd(7'h00, rdv);
      chk("cfg kept", 8'h09, rdv);
   endtask : t_sleep

   // asleep the watchdog is off, so a split frame still completes
   task automatic t_hang();
      host_model_inst.wr(7'h00, 8'h49);
      host_model_inst.gap();
      host_model_inst.put_byte(8'h80);
      repeat (2 * TMO) @(negedge clk);
      host_model_inst.put_byte(8'h09);
      repeat (10) @(negedge clk);
      chk("analog after split", 8'h01, {7'h00, analog_on});
      host_model_inst.gap();
      host_model_inst.rd(7'h00, rdv);
      chk("cfg after split", 8'h09, rdv);
   endtask : t_hang

   initial begin
      rst_n = 1'b0;
      frame_shutter = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_config();
      t_watchdog();
      t_sleep();
      t_hang();
      wrap_up();
   end
endmodule : sensor_power_down_control_test

// [serial_link.sv]
// two-wire serial engine, clocked by the host's serial clock
// assumes sck stands still between transfers; rst_n comes from a core flop
`timescale 1ns/1ps
`include "sensor_defs.svh"
module serial_link
   import sensor_pkg::*;
(
   // link clock and reset
   input wire logic sck,
   input wire logic rst_n,
   // data pin
   input wire logic sdio_in,
   output logic sdo,
   output logic oe,
   // core side
   input wire logic [7:0] cfg,
   output logic busy,
   output logic wr_tog,
   output logic [6:0] addr,
   output logic [7:0] wdata
);

   link_state_t q;
   link_state_t d;

   always_comb begin
      logic [7:0] rd;
      rd = 8'h00;
      d = q;
      // cfg is static for many sck edges around any read, so a plain bus sync holds
      d.cfg_s1 = cfg;
      d.cfg_s2 = q.cfg_s1;
      d.bit_cnt = (q.bit_cnt == 5'(`XFER_BITS - 1)) ? 5'h00 : q.bit_cnt + 5'h01;
      d.busy = (d.bit_cnt != 5'h00);
      if (q.bit_cnt < 5'h08) begin
         d.shift = {q.shift[6:0], sdio_in};
         if (q.bit_cnt == 5'h07) begin
            d.dir = q.shift[6];
            d.addr = {q.shift[5:0], sdio_in};
            if (!q.shift[6]) begin
               // unmapped addresses read as zero
               if ({q.shift[5:0], sdio_in} == `CFG_ADDR) begin
                  rd = q.cfg_s2;
               end
               d.sdo = rd[7];
               d.oe = !q.cfg_s2[`SLEEP_REQUEST_BIT];
               d.shift = {rd[6:0], 1'b0};
            end
         end
      end else if (q.dir) begin
         d.shift = {q.shift[6:0], sdio_in};
         if (q.bit_cnt == 5'(`XFER_BITS - 1)) begin
            d.wdata = {q.shift[6:0], sdio_in};
            d.wr_tog = !q.wr_tog;
         end
      end else begin
         d.sdo = q.shift[7];
         d.shift = {q.shift[6:0], 1'b0};
         if (q.bit_cnt == 5'(`XFER_BITS - 1)) begin
            d.oe = 1'b0;
         end
      end
   end

   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sdo = q.sdo;
   assign oe = q.oe;
   assign busy = q.busy;
   assign wr_tog = q.wr_tog;
   assign addr = q.addr;
   assign wdata = q.wdata;

   a_write_done: assert property (@(posedge sck) disable iff (!rst_n)
      (q.bit_cnt == 5'h0f && q.dir) |=> (q.wr_tog != $past(q.wr_tog)) && !q.busy)
      else $error("write frame did not complete on 16th edge");

   a_read_release: assert property (@(posedge sck) disable iff (!rst_n)
      (q.bit_cnt == 5'h0f) |=> !q.oe)
      else $error("data line still driven after last read bit");

endmodule : serial_link
